// *** hw/panel_seq_params.svh ***
// Constants for the drive panel power sequencer: offsets, fields, resets and timing.
`ifndef PANEL_SEQ_PARAMS_SVH
`define PANEL_SEQ_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define PSEQ_OFS_CTRL 8'h00
`define PSEQ_OFS_STATUS 8'h04
`define PSEQ_OFS_FAULT 8'h08

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PSEQ_CTRL_COVER_FITTED 0
`define PSEQ_CTRL_FAULT_CLEAR 1
`define PSEQ_ST_STATE_LSB 0
`define PSEQ_ST_STATE_MSB 2
`define PSEQ_ST_FAULT 3
`define PSEQ_ST_WPROT 4
`define PSEQ_ST_START 5
`define PSEQ_ST_REMOTE 6
`define PSEQ_ST_READY 7
`define PSEQ_ST_COVER 8

// Panel switch bit positions within the switch vector.
`define PSEQ_SW_START 0
`define PSEQ_SW_FAULT 1
`define PSEQ_SW_WPROT 2
`define PSEQ_SW_MAINT 3

// ----------------------------------------------------------------------------
// Reset values and bus response codes
// ----------------------------------------------------------------------------
`define PSEQ_CTRL_RESET 32'h0000_0001
`define PSEQ_RESP_OKAY 2'h0
`define PSEQ_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PSEQ_CLK_PERIOD_NS 4
`define PSEQ_DEBOUNCE_MS 10
`define PSEQ_BLINK_HALF_MS 250
`define PSEQ_COVER_LOCK_S 30
`define PSEQ_DEBOUNCE_CYC ((`PSEQ_DEBOUNCE_MS * 1000000 + `PSEQ_CLK_PERIOD_NS - 1) / `PSEQ_CLK_PERIOD_NS)
`define PSEQ_BLINK_CYC ((`PSEQ_BLINK_HALF_MS * 1000000) / `PSEQ_CLK_PERIOD_NS)
`define PSEQ_COVER_CYC ((`PSEQ_COVER_LOCK_S * 64'd1000000000 + `PSEQ_CLK_PERIOD_NS - 1) / `PSEQ_CLK_PERIOD_NS)

`endif

// *** hw/panel_seq_pkg.sv ***
// Types shared by the drive panel power sequencer.
package panel_seq_pkg;

    typedef enum logic [2:0] {
        st_off,
        st_spin_up,
        st_load,
        st_ready,
        st_unload,
        st_spin_down
    } seq_state_t;

    // Raw panel switches, one bit each, high while pressed.
    typedef struct packed {
        logic maint_clear;
        logic write_protect;
        logic fault_clear;
        logic start;
    } panel_sw_t;

    // Feedback from the spindle and actuator.
    typedef struct packed {
        logic spindle_stopped;
        logic heads_unloaded;
        logic heads_loaded;
        logic spindle_at_speed_relay;
    } drive_sense_t;

    // Commands to the spindle, actuator, write drivers and cover.
    typedef struct packed {
        logic cover_lock;
        logic write_inhibit;
        logic head_load;
        logic spindle_motor_on;
    } drive_ctl_t;

    // Panel lamps.
    typedef struct packed {
        logic start_led;
        logic write_protect_led;
        logic fault_led;
        logic ready_led;
    } panel_led_t;

    // Sequence power pair, pick and hold.
    typedef struct packed {
        logic hold;
        logic pick;
    } seq_pair_t;

endpackage

// *** hw/drive_panel_power_sequencer.sv ***
// Operator panel and power sequencing control for a removable-pack disk drive.
//
// Summary of operation
// - Ready lamp steady only when at speed, heads loaded and no fault.
// - Ready lamp blinks throughout power-on and power-off sequences.
// - Any fault condition sets a latched fault flag and lights the fault lamp.
// - A clear drops the fault flag only once the fault condition is gone.
// - Clear comes from panel switch, controller request, maintenance switch or a CTRL register write.
// - Write protect on lights its lamp and inhibits the write drivers.
// - Pressing write protect again removes the inhibit; the switch toggles.
// - Local mode: start switch on begins power-on with no controller signal.
// - Remote mode: power-on needs start on and controller power enable.
// - Spindle starts first; heads load only after spindle reaches speed.
// - Local mode: start switch off begins power-off and darkens its lamp.
// - Remote mode: start off or power enable dropped begins power-off.
// - Power-off unloads heads, stops spindle, darkens ready lamp.
// - Cover-lock variant keeps the cover locked about 30 s after power-up.
// - Daisy chain: participating drive forwards sequence pair once at speed.
`timescale 1ns/1ps
`include "panel_seq_params.svh"

module drive_panel_power_sequencer #(
    parameter int DEBOUNCE_CYC = `PSEQ_DEBOUNCE_CYC,
    parameter int BLINK_CYC = `PSEQ_BLINK_CYC,
    parameter longint COVER_CYC = `PSEQ_COVER_CYC,
    parameter int FAULT_W = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Operator panel
    input wire panel_seq_pkg::panel_sw_t panel_sw,
    input wire logic remote_mode,
    output panel_seq_pkg::panel_led_t panel_led,
    // Controller
    input wire panel_seq_pkg::seq_pair_t seq_in,
    input wire logic fault_clear_req,
    output panel_seq_pkg::seq_pair_t seq_out,
    // Drive mechanics
    input wire panel_seq_pkg::drive_sense_t drive_sense,
    input wire logic [FAULT_W-1:0] fault_cond,
    output panel_seq_pkg::drive_ctl_t drive_ctl
);

    localparam int DB_W = $clog2(DEBOUNCE_CYC + 1);
    localparam int BL_W = $clog2(BLINK_CYC + 1);
    localparam int CV_W = $clog2(COVER_CYC + 1);

    // ------------------------------------------------------------------------
    // Panel switch conditioning
    // ------------------------------------------------------------------------
    wire logic [3:0] sw_raw = panel_sw;
    wire logic [3:0] sw_level;
    wire logic [3:0] sw_press;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_sw
            logic sync1;
            logic sync2;
            logic stable;
            logic stable_d;
            logic [DB_W-1:0] cnt;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    sync1 <= 1'b0;
                    sync2 <= 1'b0;
                    stable <= 1'b0;
                    stable_d <= 1'b0;
                    cnt <= '0;
                end else begin
                    sync1 <= sw_raw[g];
                    sync2 <= sync1;
                    stable_d <= stable;
                    if (sync2 == stable) begin
                        cnt <= '0;
                    end else if (cnt == DB_W'(DEBOUNCE_CYC - 1)) begin
                        stable <= sync2;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
            end
            assign sw_level[g] = stable;
            assign sw_press[g] = stable & ~stable_d;
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Register bus slave
    // ------------------------------------------------------------------------
    logic [31:0] ctrl;
    logic soft_clear;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic fault_flag;
    logic write_protect;
    logic start_on;
    logic cover_timer_run;
    panel_seq_pkg::seq_state_t state;

    wire logic aw_take = awvalid & awready;
    wire logic w_take = wvalid & wready;
    wire logic ar_take = arvalid & arready;
    wire logic do_write = aw_held & w_held & ~bvalid;
    wire logic wr_ctrl = do_write & (aw_addr_q[7:2] == 6'(`PSEQ_OFS_CTRL >> 2));
    wire logic wr_known = wr_ctrl | (aw_addr_q[7:2] == 6'(`PSEQ_OFS_STATUS >> 2))
                          | (aw_addr_q[7:2] == 6'(`PSEQ_OFS_FAULT >> 2));
    wire logic rd_ctrl = araddr[7:2] == 6'(`PSEQ_OFS_CTRL >> 2);
    wire logic rd_status = araddr[7:2] == 6'(`PSEQ_OFS_STATUS >> 2);
    wire logic rd_fault = araddr[7:2] == 6'(`PSEQ_OFS_FAULT >> 2);
    wire logic cover_fitted = ctrl[`PSEQ_CTRL_COVER_FITTED];

    wire logic [31:0] status_word = {23'h0, drive_ctl.cover_lock, panel_led.ready_led, remote_mode,
                                     start_on, write_protect, fault_flag, 3'(state)};
    wire logic [31:0] ctrl_word = {31'h0, cover_fitted};
    wire logic [31:0] fault_word = 32'(fault_cond);
    wire logic [31:0] rd_word = rd_ctrl ? ctrl_word : rd_status ? status_word : rd_fault ? fault_word : 32'h0;
    wire logic rd_known = rd_ctrl | rd_status | rd_fault;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 8'h0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
        end else begin
            awready <= awvalid & ~awready & ~aw_held & ~bvalid;
            wready <= wvalid & ~wready & ~w_held & ~bvalid;
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr_q <= awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `PSEQ_RESP_OKAY;
            ctrl <= `PSEQ_CTRL_RESET;
            soft_clear <= 1'b0;
        end else begin
            soft_clear <= wr_ctrl & w_strb_q[0] & w_data_q[`PSEQ_CTRL_FAULT_CLEAR];
            if (wr_ctrl && w_strb_q[0]) begin
                ctrl <= {31'h0, w_data_q[`PSEQ_CTRL_COVER_FITTED]};
            end
            if (do_write) begin
                bvalid <= 1'b1;
                bresp <= wr_known ? `PSEQ_RESP_OKAY : `PSEQ_RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `PSEQ_RESP_OKAY;
        end else begin
            arready <= arvalid & ~arready & ~rvalid;
            if (ar_take) begin
                rvalid <= 1'b1;
                rdata <= rd_word;
                rresp <= rd_known ? `PSEQ_RESP_OKAY : `PSEQ_RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Start, write protect and fault latches
    // ------------------------------------------------------------------------
    wire logic any_fault = |fault_cond;
    wire logic clear_any = sw_press[`PSEQ_SW_FAULT] | fault_clear_req | sw_press[`PSEQ_SW_MAINT]
                           | soft_clear;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_on <= 1'b0;
            write_protect <= 1'b0;
            fault_flag <= 1'b0;
        end else begin
            if (sw_press[`PSEQ_SW_START]) begin
                start_on <= ~start_on;
            end
            if (sw_press[`PSEQ_SW_WPROT]) begin
                write_protect <= ~write_protect;
            end
            // A live condition keeps the flag set even when a clear arrives.
            if (any_fault) begin
                fault_flag <= 1'b1;
            end else if (clear_any) begin
                fault_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Power sequence
    // ------------------------------------------------------------------------
    wire logic seq_enable = seq_in.pick & seq_in.hold;
    wire logic power_req = start_on & (~remote_mode | seq_enable);
    panel_seq_pkg::seq_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            panel_seq_pkg::st_off: begin
                if (power_req) begin
                    next_state = panel_seq_pkg::st_spin_up;
                end
            end
            panel_seq_pkg::st_spin_up: begin
                if (!power_req) begin
                    next_state = panel_seq_pkg::st_unload;
                end else if (drive_sense.spindle_at_speed_relay) begin
                    next_state = panel_seq_pkg::st_load;
                end
            end
            panel_seq_pkg::st_load: begin
                if (!power_req) begin
                    next_state = panel_seq_pkg::st_unload;
                end else if (drive_sense.heads_loaded) begin
                    next_state = panel_seq_pkg::st_ready;
                end
            end
            panel_seq_pkg::st_ready: begin
                if (!power_req) begin
                    next_state = panel_seq_pkg::st_unload;
                end
            end
            panel_seq_pkg::st_unload: begin
                if (drive_sense.heads_unloaded) begin
                    next_state = panel_seq_pkg::st_spin_down;
                end
            end
            panel_seq_pkg::st_spin_down: begin
                if (drive_sense.spindle_stopped) begin
                    next_state = panel_seq_pkg::st_off;
                end
            end
            default: begin
                next_state = panel_seq_pkg::st_off;
            end
        endcase
    end

    wire logic in_sequence = (state == panel_seq_pkg::st_spin_up) | (state == panel_seq_pkg::st_load)
                             | (state == panel_seq_pkg::st_unload) | (state == panel_seq_pkg::st_spin_down);
    wire logic next_motor = (next_state == panel_seq_pkg::st_spin_up) | (next_state == panel_seq_pkg::st_load)
                            | (next_state == panel_seq_pkg::st_ready) | (next_state == panel_seq_pkg::st_unload);
    wire logic next_head_load = (next_state == panel_seq_pkg::st_load) | (next_state == panel_seq_pkg::st_ready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= panel_seq_pkg::st_off;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------------
    // Blink timer and cover lock timer
    // ------------------------------------------------------------------------
    logic [BL_W-1:0] blink_cnt;
    logic blink_phase;
    logic [CV_W-1:0] cover_cnt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_cnt <= '0;
            blink_phase <= 1'b0;
            cover_cnt <= '0;
            cover_timer_run <= 1'b1;
        end else begin
            if (blink_cnt == BL_W'(BLINK_CYC - 1)) begin
                blink_cnt <= '0;
                blink_phase <= ~blink_phase;
            end else begin
                blink_cnt <= blink_cnt + 1'b1;
            end
            // Reset stands for main power being applied; the lock runs once after it.
            if (cover_cnt == CV_W'(COVER_CYC - 1)) begin
                cover_timer_run <= 1'b0;
            end else if (cover_timer_run) begin
                cover_cnt <= cover_cnt + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------------
    wire logic steady_ready = (state == panel_seq_pkg::st_ready) & drive_sense.spindle_at_speed_relay
                              & drive_sense.heads_loaded & ~fault_flag & ~any_fault;
    wire logic participating = remote_mode & start_on;
    wire logic fwd_ok = ~participating | drive_sense.spindle_at_speed_relay;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            panel_led <= '0;
            drive_ctl <= '0;
            seq_out <= '0;
        end else begin
            panel_led.ready_led <= steady_ready | (in_sequence & blink_phase);
            panel_led.fault_led <= fault_flag | any_fault;
            panel_led.write_protect_led <= write_protect ^ sw_press[`PSEQ_SW_WPROT];
            panel_led.start_led <= start_on ^ sw_press[`PSEQ_SW_START];
            drive_ctl.spindle_motor_on <= next_motor;
            drive_ctl.head_load <= next_head_load;
            drive_ctl.write_inhibit <= write_protect ^ sw_press[`PSEQ_SW_WPROT];
            drive_ctl.cover_lock <= cover_fitted & (cover_timer_run | (state != panel_seq_pkg::st_off));
            seq_out.pick <= seq_in.pick & fwd_ok;
            seq_out.hold <= seq_in.hold & fwd_ok;
        end
    end

endmodule

// *** tb/disk_ctrl_model.sv ***
// Behavioural disk controller that drives the sequence pair and the fault clear line.
`timescale 1ns/1ps
module disk_ctrl_model (
    // Clock
    input wire logic aclk,
    // Bench commands
    input wire logic power_en_cmd,
    input wire logic clear_cmd,
    // Drive side
    output panel_seq_pkg::seq_pair_t seq_in,
    output logic fault_clear_req
);
    initial begin
        seq_in = '0;
        fault_clear_req = 1'h0;
    end

    always @(posedge aclk) begin
        seq_in.pick <= power_en_cmd;
        seq_in.hold <= power_en_cmd && seq_in.pick;
        fault_clear_req <= clear_cmd;
    end
endmodule

// *** tb/drive_panel_sva.sv ***
// Concurrent checks on the ports of the panel power sequencer.
`timescale 1ns/1ps
module drive_panel_sva #(
    parameter int FAULT_W = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Panel and controller
    input wire panel_seq_pkg::panel_sw_t panel_sw,
    input wire logic remote_mode,
    input wire panel_seq_pkg::panel_led_t panel_led,
    input wire panel_seq_pkg::seq_pair_t seq_in,
    input wire logic fault_clear_req,
    input wire panel_seq_pkg::seq_pair_t seq_out,
    // Drive mechanics
    input wire panel_seq_pkg::drive_sense_t drive_sense,
    input wire logic [FAULT_W-1:0] fault_cond,
    input wire panel_seq_pkg::drive_ctl_t drive_ctl
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ready_dark_a: assert property (
        (!drive_ctl.spindle_motor_on && !drive_ctl.head_load && drive_sense.spindle_stopped)[*4] |-> !panel_led.ready_led)
        else $error("ready lamp lit while the drive is stopped");
    head_order_a: assert property ($rose(drive_ctl.head_load) |-> $past(drive_sense.spindle_at_speed_relay))
        else $error("heads loaded before the spindle was at speed");
    fault_set_a: assert property (fault_cond != '0 |=> panel_led.fault_led)
        else $error("fault lamp dark after a fault");
    fault_clear_a: assert property ((fault_clear_req && fault_cond == '0)[*2] |=> !panel_led.fault_led)
        else $error("fault lamp lit after a clear");
    wp_lamp_a: assert property (panel_led.write_protect_led == drive_ctl.write_inhibit)
        else $error("write protect lamp and inhibit differ");
    wp_toggle_a: assert property ($changed(drive_ctl.write_inhibit) |-> $past(panel_sw.write_protect, 2))
        else $error("write inhibit changed without a press");
    power_on_a: assert property ($rose(drive_ctl.spindle_motor_on) |-> panel_led.start_led &&
        (!$past(remote_mode) || ($past(seq_in.pick) && $past(seq_in.hold))))
        else $error("spindle started without a power request");
    power_off_a: assert property ((!panel_led.start_led || (remote_mode && !(seq_in.pick && seq_in.hold)))
        |-> ##[1:2] !drive_ctl.head_load)
        else $error("heads stay loaded without a power request");
    daisy_pass_a: assert property (!$past(remote_mode) |-> seq_out == $past(seq_in))
        else $error("sequence pair not forwarded");
    daisy_hold_a: assert property (
        $past(remote_mode) && $past(panel_led.start_led) && !$past(drive_sense.spindle_at_speed_relay) |-> seq_out == '0)
        else $error("sequence pair forwarded before the spindle was at speed");
    cover_lock_a: assert property (aresetn && !$past(aresetn) |=> drive_ctl.cover_lock [*8])
        else $error("cover unlocked early after power-up");
endmodule

bind drive_panel_power_sequencer drive_panel_sva #(.FAULT_W(FAULT_W)) drive_panel_sva_i (
    .aclk, .aresetn, .panel_sw, .remote_mode, .panel_led, .seq_in, .fault_clear_req, .seq_out,
    .drive_sense, .fault_cond, .drive_ctl);

// *** tb/drive_panel_power_sequencer_tb.sv ***
// Self-checking bench for the panel power sequencer.
`timescale 1ns/1ps
`include "panel_seq_params.svh"
module drive_panel_power_sequencer_tb;
    logic aclk = '0;
    logic aresetn = '0;
    logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp;
    logic remote_mode = '0, power_en = '0, clr = '0, fault_clear_req;
    logic [7:0] fault_cond = '0;
    panel_seq_pkg::panel_sw_t panel_sw = '0;
    panel_seq_pkg::panel_led_t led;
    panel_seq_pkg::seq_pair_t seq_in, seq_out;
    panel_seq_pkg::drive_sense_t sense;
    panel_seq_pkg::drive_ctl_t ctl;
    logic [4:0] spd = '0;
    logic [2:0] hd = '0;
    int failures = 0, cmp_count = 0, cyc = 0;
    always #2 aclk = ~aclk;

    drive_panel_power_sequencer #(.DEBOUNCE_CYC(4), .BLINK_CYC(8), .COVER_CYC(50)) drive_panel_power_sequencer_i (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb,
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
        .panel_sw, .remote_mode, .panel_led(led), .seq_in, .fault_clear_req, .seq_out,
        .drive_sense(sense), .fault_cond, .drive_ctl(ctl));
    disk_ctrl_model disk_ctrl_model_i (.aclk, .power_en_cmd(power_en), .clear_cmd(clr), .seq_in, .fault_clear_req);

    // ------------------------------------------------------------------------
    // Mechanics: spindle takes 20 cycles to start or stop, heads 5.
    // ------------------------------------------------------------------------
    assign sense = {spd == 5'h00, hd == 3'h0, hd == 3'h5, spd == 5'h14};
    always @(posedge aclk) begin
        spd <= ctl.spindle_motor_on ? spd + {4'h0, spd != 5'h14} : spd - {4'h0, spd != 5'h00};
        hd <= ctl.head_load ? hd + {2'h0, hd != 3'h5} : hd - {2'h0, hd != 3'h0};
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks=%0d failures=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            awvalid <= awvalid && !awready;
            wvalid <= wvalid && !wready;
        end while (!bvalid);
        bready <= 1'h0;
        chk(bresp, er);
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            arvalid <= arvalid && !arready;
        end while (!rvalid);
        rready <= 1'h0;
        d = rdata;
        chk(rresp, er);
        @(posedge aclk);
    endtask

    task automatic press(input int i);
        panel_sw[i] <= 1'h1;
        repeat (12) @(posedge aclk);
        panel_sw[i] <= 1'h0;
        repeat (12) @(posedge aclk);
    endtask

    task automatic wait_st(input panel_seq_pkg::seq_state_t s);
        logic [31:0] d;
        int n = 0;
        do begin
            rd(`PSEQ_OFS_STATUS, d, `PSEQ_RESP_OKAY);
            n++;
        end while (d[2:0] !== s && n < 40);
        chk(d[2:0], s);
    endtask

    task automatic t_regs();
        logic [31:0] d;
        chk(ctl.cover_lock, 1'h1);
        wstrb <= 4'he;
        wr(`PSEQ_OFS_CTRL, 32'h0, `PSEQ_RESP_OKAY);
        wstrb <= 4'hf;
        rd(`PSEQ_OFS_CTRL, d, `PSEQ_RESP_OKAY);
        chk(d, `PSEQ_CTRL_RESET);
        rd(8'h40, d, `PSEQ_RESP_SLVERR);
        chk(d, 32'h0);
        wr(8'h40, 32'hffff_ffff, `PSEQ_RESP_SLVERR);
        wr(`PSEQ_OFS_STATUS, 32'h0000_00ff, `PSEQ_RESP_OKAY);
        wait_st(panel_seq_pkg::st_off);
        repeat (60) @(posedge aclk);
        chk(ctl.cover_lock, 1'h0);
    endtask

    task automatic t_local();
        int ones = 0;
        panel_sw.start <= 1'h1;
        repeat (12) @(posedge aclk);
        chk({ctl.spindle_motor_on, ctl.head_load}, 2'h2);
        for (int i = 0; i < 16; i++) begin
            @(posedge aclk);
            ones += led.ready_led;
        end
        chk(ones > 0 && ones < 16, 1'h1);
        panel_sw.start <= 1'h0;
        wait_st(panel_seq_pkg::st_ready);
        for (int i = 0; i < 2; i++) begin
            repeat (9) @(posedge aclk);
            chk({led.ready_led, ctl.head_load, ctl.cover_lock}, 3'h7);
        end
        fault_cond <= 8'h01;
        repeat (3) @(posedge aclk);
        chk(led.ready_led, 1'h0);
        fault_cond <= 8'h00;
        clr <= 1'h1;
        repeat (3) @(posedge aclk);
        clr <= 1'h0;
        repeat (4) @(posedge aclk);
        chk(led.ready_led, 1'h1);
        press(`PSEQ_SW_START);
        chk(led.start_led, 1'h0);
        wait_st(panel_seq_pkg::st_off);
        chk({led.ready_led, ctl.head_load, ctl.spindle_motor_on}, 3'h0);
    endtask

    task automatic t_remote();
        remote_mode <= 1'h1;
        press(`PSEQ_SW_START);
        repeat (20) @(posedge aclk);
        chk(ctl.spindle_motor_on, 1'h0);
        power_en <= 1'h1;
        repeat (12) @(posedge aclk);
        chk({ctl.spindle_motor_on, seq_out}, 3'h4);
        wait_st(panel_seq_pkg::st_ready);
        chk(seq_out, 2'h3);
        power_en <= 1'h0;
        wait_st(panel_seq_pkg::st_off);
        press(`PSEQ_SW_START);
        power_en <= 1'h1;
        repeat (4) @(posedge aclk);
        chk({ctl.spindle_motor_on, seq_out}, 3'h3);
        power_en <= 1'h0;
        remote_mode <= 1'h0;
    endtask

    task automatic t_fault();
        for (int i = 0; i < 4; i++) begin
            fault_cond <= 8'h80 >> i;
            clr <= 1'h1;
            repeat (3) @(posedge aclk);
            clr <= 1'h0;
            repeat (2) @(posedge aclk);
            chk(led.fault_led, 1'h1);
            fault_cond <= 8'h00;
            repeat (4) @(posedge aclk);
            chk(led.fault_led, 1'h1);
            if (i == 3) begin
                wr(`PSEQ_OFS_CTRL, 32'h0000_0003, `PSEQ_RESP_OKAY);
            end else if (i == 2) begin
                clr <= 1'h1;
                repeat (2) @(posedge aclk);
                clr <= 1'h0;
            end else begin
                press(i == 0 ? `PSEQ_SW_FAULT : `PSEQ_SW_MAINT);
            end
            repeat (4) @(posedge aclk);
            chk(led.fault_led, 1'h0);
        end
    endtask

    task automatic t_wp();
        press(`PSEQ_SW_WPROT);
        chk({led.write_protect_led, ctl.write_inhibit}, 2'h3);
        panel_sw.write_protect <= 1'h1;
        repeat (2) @(posedge aclk);
        panel_sw.write_protect <= 1'h0;
        repeat (12) @(posedge aclk);
        chk(ctl.write_inhibit, 1'h1);
        press(`PSEQ_SW_WPROT);
        chk({led.write_protect_led, ctl.write_inhibit}, 2'h0);
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        t_regs();
        t_local();
        t_remote();
        t_fault();
        t_wp();
        report_and_stop();
    end
endmodule
